// [logic/eip_pkg.sv]
package eip_pkg;
    localparam int NUM_LEVELS = 8;
    localparam int NUM_SRC = 16;
    localparam int SRC_PER_LEVEL = 2;

    // Register file addresses
    localparam logic [7:0] ADDR_FAST_PTR_HI = 8'hDA;
    localparam logic [7:0] ADDR_FAST_PTR_LO = 8'hDB;
    localparam logic [7:0] ADDR_REQ_STATUS = 8'hDC;
    localparam logic [7:0] ADDR_LEVEL_MASK = 8'hDD;
    localparam logic [7:0] ADDR_SYS_MODE = 8'hDE;
    localparam logic [7:0] ADDR_PRIO_CFG = 8'hFF;

    // System mode fields
    localparam int SYM_GLOBAL_EN = 0;
    localparam int SYM_FAST_EN = 1;
    localparam int SYM_FAST_SEL_LSB = 2;
    localparam int SYM_FAST_SEL_MSB = 4;

    // Priority configuration fields
    localparam int PRIO_A_ORDER = 0;
    localparam int PRIO_GRP_BIT0 = 1;
    localparam int PRIO_B_TOP = 2;
    localparam int PRIO_B_SUB = 3;
    localparam int PRIO_GRP_BIT1 = 4;
    localparam int PRIO_C_TOP = 5;
    localparam int PRIO_C_SUB = 6;
    localparam int PRIO_GRP_BIT2 = 7;

    // Group orderings selected by the three group bits
    localparam logic [2:0] GRP_B_C_A = 3'h1;
    localparam logic [2:0] GRP_A_B_C = 3'h2;
    localparam logic [2:0] GRP_B_A_C = 3'h3;
    localparam logic [2:0] GRP_C_A_B = 3'h4;
    localparam logic [2:0] GRP_C_B_A = 3'h5;
    localparam logic [2:0] GRP_A_C_B = 3'h6;

    // Reset values of the writable registers
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;

    // Vector table base; source s uses base + 2*s (even, inside 00H-FFH)
    localparam logic [7:0] VEC_BASE = 8'h80;

    // Sources whose pending bit hardware clears on acknowledge
    localparam logic [15:0] HW_CLEAR_SRC = 16'h01D5;

    typedef enum logic [3:0] {
        ST_IDLE     = 4'h0,
        ST_PUSH_L   = 4'h1,
        ST_PUSH_H   = 4'h2,
        ST_PUSH_F   = 4'h3,
        ST_FETCH_H  = 4'h4,
        ST_FETCH_L  = 4'h5,
        ST_BRANCH   = 4'h6,
        ST_FAST_IN  = 4'h7,
        ST_FAST_OUT = 4'h8,
        ST_POP_F    = 4'h9,
        ST_POP_H    = 4'hA,
        ST_POP_L    = 4'hB,
        ST_RESTORE  = 4'hC
    } eip_state_e;
endpackage

// [logic/eip_pend_cell.sv]
`timescale 1ns/100ps
module eip_pend_cell (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic set_pulse,
    input wire logic clr_pulse,
    output logic pend
);
    // A request in the clearing cycle survives: set beats clear
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pend <= 1'b0;
        end else if (ce) begin
            if (set_pulse) begin
                pend <= 1'b1;
            end else if (clr_pulse) begin
                pend <= 1'b0;
            end
        end
    end
endmodule

// [logic/eip_unit.sv]
`timescale 1ns/100ps
module eip_unit (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [15:0] src_req,
    input wire logic [15:0] src_en,
    input wire logic [15:0] src_sw_clr,
    input wire logic instr_end,
    input wire logic global_enable_instr,
    input wire logic global_disable_instr,
    input wire logic return_from_interrupt,
    input wire logic [15:0] pc_in,
    input wire logic [7:0] flags_in,
    input wire logic [7:0] vec_rdata,
    input wire logic [7:0] stk_rdata,
    output logic irq_req,
    output logic acknowledge_strobe,
    output logic stk_push,
    output logic [7:0] stk_wdata,
    output logic stk_pop,
    output logic vec_rd,
    output logic [7:0] vec_addr,
    output logic pc_load,
    output logic [15:0] pc_new,
    output logic flags_load,
    output logic [7:0] flags_new,
    output logic fast_status,
    output logic busy
);
    eip_pkg::eip_state_e state_reg;
    logic [7:0] prio_cfg_reg;
    logic [7:0] level_mask_reg;
    logic global_en_reg;
    logic fast_en_reg;
    logic [2:0] fast_sel_reg;
    logic [15:0] fast_vector_pointer;
    logic [7:0] shadow_flags_reg;
    logic [7:0] request_status_reg;
    logic [3:0] src_sel_reg;
    logic [7:0] vec_hi_reg;
    logic [15:0] pend;
    logic [15:0] clr;
    logic [15:0] pend_act;
    logic [7:0] level_pend;
    logic [7:0] level_act;
    logic [7:0] eligible;
    logic [23:0] order;
    logic [5:0] grp_a;
    logic [8:0] grp_b;
    logic [8:0] grp_c;
    logic [5:0] sub_b;
    logic [5:0] sub_c;
    logic [2:0] win_lvl;
    logic win_valid;
    logic [3:0] win_src;
    logic take;

    // Pending bits; hardware-cleared ones clear on acknowledge only
    genvar g;
    generate
        for (g = 0; g < eip_pkg::NUM_SRC; g++) begin : g_pend
            assign clr[g] = eip_pkg::HW_CLEAR_SRC[g] ?
                (take && win_src == 4'(g)) : src_sw_clr[g];
            eip_pend_cell u_cell (
                .ref_clk(ref_clk),
                .rstn(rstn),
                .ce(ce),
                .set_pulse(src_req[g]),
                .clr_pulse(clr[g]),
                .pend(pend[g])
            );
            if (g % eip_pkg::SRC_PER_LEVEL == 0) begin : g_lvl
                assign level_pend[g / 2] = pend[g] | pend[g + 1];
                assign level_act[g / 2] = pend_act[g] | pend_act[g + 1];
            end
        end
    endgenerate

    // Source enable gates service but not the status view
    assign pend_act = pend & src_en;
    assign eligible = global_en_reg ? (level_act & level_mask_reg) : 8'h00;

    // Priority order list, highest first, rebuilt every cycle
    always_comb begin
        grp_a = prio_cfg_reg[eip_pkg::PRIO_A_ORDER] ?
            {3'h1, 3'h0} : {3'h0, 3'h1};
        sub_b = prio_cfg_reg[eip_pkg::PRIO_B_SUB] ?
            {3'h4, 3'h3} : {3'h3, 3'h4};
        grp_b = prio_cfg_reg[eip_pkg::PRIO_B_TOP] ?
            {sub_b, 3'h2} : {3'h2, sub_b};
        sub_c = prio_cfg_reg[eip_pkg::PRIO_C_SUB] ?
            {3'h7, 3'h6} : {3'h6, 3'h7};
        grp_c = prio_cfg_reg[eip_pkg::PRIO_C_TOP] ?
            {sub_c, 3'h5} : {3'h5, sub_c};
        case ({prio_cfg_reg[eip_pkg::PRIO_GRP_BIT2],
               prio_cfg_reg[eip_pkg::PRIO_GRP_BIT1],
               prio_cfg_reg[eip_pkg::PRIO_GRP_BIT0]})
            eip_pkg::GRP_B_C_A: order = {grp_b, grp_c, grp_a};
            eip_pkg::GRP_A_B_C: order = {grp_a, grp_b, grp_c};
            eip_pkg::GRP_B_A_C: order = {grp_b, grp_a, grp_c};
            eip_pkg::GRP_C_A_B: order = {grp_c, grp_a, grp_b};
            eip_pkg::GRP_C_B_A: order = {grp_c, grp_b, grp_a};
            eip_pkg::GRP_A_C_B: order = {grp_a, grp_c, grp_b};
            default: order = {grp_a, grp_b, grp_c};
        endcase
    end

    // Walk lowest to highest so the top eligible level overwrites last
    always_comb begin
        win_lvl = 3'h0;
        win_valid = 1'b0;
        for (int i = 0; i < eip_pkg::NUM_LEVELS; i++) begin
            if (eligible[order[i * 3 +: 3]]) begin
                win_lvl = order[i * 3 +: 3];
                win_valid = 1'b1;
            end
        end
        // Lower slot means lower vector address
        win_src = pend_act[{win_lvl, 1'b0}] ?
            {win_lvl, 1'b0} : {win_lvl, 1'b1};
    end

    assign take = (state_reg == eip_pkg::ST_IDLE) && instr_end && win_valid
        && !return_from_interrupt;

    // Sequencer for entry, fast entry and both kinds of return
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= eip_pkg::ST_IDLE;
            src_sel_reg <= 4'h0;
            vec_hi_reg <= eip_pkg::RST_BYTE;
            acknowledge_strobe <= 1'b0;
            stk_push <= 1'b0;
            stk_wdata <= eip_pkg::RST_BYTE;
            stk_pop <= 1'b0;
            vec_rd <= 1'b0;
            vec_addr <= eip_pkg::RST_BYTE;
            pc_load <= 1'b0;
            pc_new <= eip_pkg::RST_WORD;
            flags_load <= 1'b0;
            flags_new <= eip_pkg::RST_BYTE;
            busy <= 1'b0;
        end else if (ce) begin
            acknowledge_strobe <= 1'b0;
            stk_push <= 1'b0;
            stk_pop <= 1'b0;
            vec_rd <= 1'b0;
            pc_load <= 1'b0;
            flags_load <= 1'b0;
            busy <= (state_reg != eip_pkg::ST_IDLE);
            case (state_reg)
                eip_pkg::ST_IDLE: begin
                    if (return_from_interrupt) begin
                        busy <= 1'b1;
                        state_reg <= fast_status ?
                            eip_pkg::ST_FAST_OUT : eip_pkg::ST_POP_F;
                    end else if (take) begin
                        acknowledge_strobe <= 1'b1;
                        busy <= 1'b1;
                        src_sel_reg <= win_src;
                        if (fast_en_reg && win_lvl == fast_sel_reg) begin
                            state_reg <= eip_pkg::ST_FAST_IN;
                        end else begin
                            state_reg <= eip_pkg::ST_PUSH_L;
                        end
                    end
                end
                eip_pkg::ST_PUSH_L: begin
                    stk_push <= 1'b1;
                    stk_wdata <= pc_in[7:0];
                    state_reg <= eip_pkg::ST_PUSH_H;
                end
                eip_pkg::ST_PUSH_H: begin
                    stk_push <= 1'b1;
                    stk_wdata <= pc_in[15:8];
                    state_reg <= eip_pkg::ST_PUSH_F;
                end
                eip_pkg::ST_PUSH_F: begin
                    stk_push <= 1'b1;
                    stk_wdata <= flags_in;
                    state_reg <= eip_pkg::ST_FETCH_H;
                end
                eip_pkg::ST_FETCH_H: begin
                    vec_rd <= 1'b1;
                    vec_addr <= eip_pkg::VEC_BASE + {3'h0, src_sel_reg, 1'b0};
                    state_reg <= eip_pkg::ST_FETCH_L;
                end
                eip_pkg::ST_FETCH_L: begin
                    vec_rd <= 1'b1;
                    vec_addr <= vec_addr | 8'h01;
                    vec_hi_reg <= vec_rdata;
                    state_reg <= eip_pkg::ST_BRANCH;
                end
                eip_pkg::ST_BRANCH: begin
                    pc_load <= 1'b1;
                    pc_new <= {vec_hi_reg, vec_rdata};
                    state_reg <= eip_pkg::ST_IDLE;
                end
                eip_pkg::ST_FAST_IN: begin
                    pc_load <= 1'b1;
                    pc_new <= fast_vector_pointer;
                    state_reg <= eip_pkg::ST_IDLE;
                end
                eip_pkg::ST_FAST_OUT: begin
                    pc_load <= 1'b1;
                    pc_new <= fast_vector_pointer;
                    flags_load <= 1'b1;
                    flags_new <= shadow_flags_reg;
                    state_reg <= eip_pkg::ST_IDLE;
                end
                eip_pkg::ST_POP_F: begin
                    stk_pop <= 1'b1;
                    state_reg <= eip_pkg::ST_POP_H;
                end
                eip_pkg::ST_POP_H: begin
                    stk_pop <= 1'b1;
                    flags_new <= stk_rdata;
                    state_reg <= eip_pkg::ST_POP_L;
                end
                eip_pkg::ST_POP_L: begin
                    stk_pop <= 1'b1;
                    pc_new[15:8] <= stk_rdata;
                    state_reg <= eip_pkg::ST_RESTORE;
                end
                eip_pkg::ST_RESTORE: begin
                    pc_load <= 1'b1;
                    flags_load <= 1'b1;
                    pc_new[7:0] <= stk_rdata;
                    state_reg <= eip_pkg::ST_IDLE;
                end
                default: state_reg <= eip_pkg::ST_IDLE;
            endcase
        end
    end

    // Mode register; entry clears and return sets the global enable
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            global_en_reg <= 1'b0;
            fast_en_reg <= 1'b0;
            fast_sel_reg <= 3'h0;
        end else if (ce) begin
            if (take) begin
                global_en_reg <= 1'b0;
            end else if (state_reg == eip_pkg::ST_RESTORE ||
                         state_reg == eip_pkg::ST_FAST_OUT) begin
                global_en_reg <= 1'b1;
            end else if (global_enable_instr) begin
                global_en_reg <= 1'b1;
            end else if (global_disable_instr) begin
                global_en_reg <= 1'b0;
            end else if (reg_wr && reg_addr == eip_pkg::ADDR_SYS_MODE) begin
                global_en_reg <= reg_wdata[eip_pkg::SYM_GLOBAL_EN];
            end
            if (reg_wr && reg_addr == eip_pkg::ADDR_SYS_MODE) begin
                fast_en_reg <= reg_wdata[eip_pkg::SYM_FAST_EN];
                fast_sel_reg <= reg_wdata[eip_pkg::SYM_FAST_SEL_MSB:
                                          eip_pkg::SYM_FAST_SEL_LSB];
            end
        end
    end

    // Fast pointer swaps with the PC on fast entry and exit
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            fast_vector_pointer <= eip_pkg::RST_WORD;
        end else if (ce) begin
            if (state_reg == eip_pkg::ST_FAST_IN ||
                state_reg == eip_pkg::ST_FAST_OUT) begin
                fast_vector_pointer <= pc_in;
            end else if (reg_wr && reg_addr == eip_pkg::ADDR_FAST_PTR_HI) begin
                fast_vector_pointer[15:8] <= reg_wdata;
            end else if (reg_wr && reg_addr == eip_pkg::ADDR_FAST_PTR_LO) begin
                fast_vector_pointer[7:0] <= reg_wdata;
            end
        end
    end

    // Shadow flags and fast status; shadow has no address
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            shadow_flags_reg <= eip_pkg::RST_BYTE;
            fast_status <= 1'b0;
        end else if (ce) begin
            if (state_reg == eip_pkg::ST_FAST_IN) begin
                shadow_flags_reg <= flags_in;
                fast_status <= 1'b1;
            end else if (state_reg == eip_pkg::ST_FAST_OUT) begin
                fast_status <= 1'b0;
            end
        end
    end

    // Software-written configuration; undefined after reset, zero here
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            prio_cfg_reg <= eip_pkg::RST_BYTE;
            level_mask_reg <= eip_pkg::RST_BYTE;
        end else if (ce && reg_wr) begin
            if (reg_addr == eip_pkg::ADDR_PRIO_CFG) begin
                prio_cfg_reg <= reg_wdata;
            end
            if (reg_addr == eip_pkg::ADDR_LEVEL_MASK) begin
                level_mask_reg <= reg_wdata;
            end
        end
    end

    // Status view, CPU request line and read data, one cycle behind
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            request_status_reg <= eip_pkg::RST_BYTE;
            irq_req <= 1'b0;
            reg_rdata <= eip_pkg::RST_BYTE;
        end else if (ce) begin
            request_status_reg <= level_pend;
            irq_req <= win_valid && state_reg == eip_pkg::ST_IDLE;
            case (reg_addr)
                eip_pkg::ADDR_FAST_PTR_HI: reg_rdata <= fast_vector_pointer[15:8];
                eip_pkg::ADDR_FAST_PTR_LO: reg_rdata <= fast_vector_pointer[7:0];
                eip_pkg::ADDR_REQ_STATUS: reg_rdata <= request_status_reg;
                eip_pkg::ADDR_LEVEL_MASK: reg_rdata <= level_mask_reg;
                eip_pkg::ADDR_SYS_MODE:
                    reg_rdata <= {3'h0, fast_sel_reg, fast_en_reg, global_en_reg};
                eip_pkg::ADDR_PRIO_CFG: reg_rdata <= prio_cfg_reg;
                default: reg_rdata <= eip_pkg::RST_BYTE;
            endcase
        end
    end

    // Assertions hold while the clock enable stays high
    sequence s_vec_entry;
        stk_push ##1 stk_push ##1 stk_push ##1 vec_rd ##1 vec_rd ##1 pc_load;
    endsequence

    a_entry_order: assert property (@(posedge ref_clk) disable iff (!rstn || !ce)
        $rose(state_reg == eip_pkg::ST_PUSH_L) |=> s_vec_entry)
        else $error("vectored entry steps out of order");
    a_ack_clears_ge: assert property (@(posedge ref_clk) disable iff (!rstn || !ce)
        acknowledge_strobe |-> !global_en_reg && $past(global_en_reg))
        else $error("acknowledge without global enable drop");
    a_mask_blocks: assert property (@(posedge ref_clk) disable iff (!rstn || !ce)
        acknowledge_strobe |->
        ((($past(level_mask_reg) >> src_sel_reg[3:1]) & 8'h01) != 8'h00))
        else $error("masked level acknowledged");
    a_return_sets_ge: assert property (@(posedge ref_clk) disable iff (!rstn || !ce)
        state_reg == eip_pkg::ST_RESTORE |=> global_en_reg && pc_load && flags_load)
        else $error("return did not restore and enable");
    a_group_cba: assert property (@(posedge ref_clk) disable iff (!rstn || !ce)
        ({prio_cfg_reg[7], prio_cfg_reg[4], prio_cfg_reg[1]} == eip_pkg::GRP_C_B_A
         && eligible[5] && eligible[2] && !eligible[6] && !eligible[7])
        |-> win_lvl == 3'h5)
        else $error("group order C over B broken");
    a_fast_swap: assert property (@(posedge ref_clk) disable iff (!rstn || !ce)
        state_reg == eip_pkg::ST_FAST_IN |=> pc_load && fast_status
        && pc_new == $past(fast_vector_pointer)
        && fast_vector_pointer == $past(pc_in))
        else $error("fast entry swap wrong");
    a_fast_return: assert property (@(posedge ref_clk) disable iff (!rstn || !ce)
        state_reg == eip_pkg::ST_FAST_OUT |=> !fast_status && flags_load
        && flags_new == $past(shadow_flags_reg))
        else $error("fast return restore wrong");
    a_vector_even: assert property (@(posedge ref_clk) disable iff (!rstn || !ce)
        $rose(vec_rd) |-> !vec_addr[0] ##1 (vec_rd && vec_addr[0]))
        else $error("vector fetch not at even address pair");
    a_status_tracks: assert property (@(posedge ref_clk) disable iff (!rstn || !ce)
        ##1 request_status_reg == $past(level_pend))
        else $error("request status not following pending");
    a_no_service_off: assert property (@(posedge ref_clk) disable iff (!rstn || !ce)
        !global_en_reg && !acknowledge_strobe |=> !acknowledge_strobe)
        else $error("service while globally disabled");
endmodule

// [tb/eip_cpu_model.sv]
`timescale 1ns/100ps
module eip_cpu_model (
    input wire logic ref_clk,
    input wire logic stk_push,
    input wire logic [7:0] stk_wdata,
    input wire logic stk_pop,
    input wire logic vec_rd,
    input wire logic [7:0] vec_addr,
    output logic [7:0] vec_rdata,
    output logic [7:0] stk_rdata
);
    logic [7:0] stack [0:15];
    logic [3:0] sp = 4'h0;
    // Unit samples in the strobe cycle, so answer at once; else show inverse
    assign vec_rdata = vec_rd ? (vec_addr ^ 8'h5A) : ~vec_addr;
    // Top of stack stands during the pop cycle; inverted when not popping
    assign stk_rdata = stack[sp - 4'h1] ^ (stk_pop ? 8'h00 : 8'hFF);
    // Stack is LIFO
    always @(posedge ref_clk) begin
        if (stk_push) begin
            stack[sp] <= stk_wdata;
            sp <= sp + 4'h1;
        end
        if (stk_pop) begin
            sp <= sp - 4'h1;
        end
    end
endmodule

// [tb/tb.sv]
`timescale 1ns/100ps
module tb;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [15:0] src_req = 16'h0000;
    logic [15:0] src_en = 16'hFFFF;
    logic [15:0] src_sw_clr = 16'h0000;
    logic [3:0] pv = 4'h0;
    logic [7:0] reg_rdata, vec_rdata, stk_rdata, stk_wdata, vec_addr;
    logic [7:0] flags_new;
    logic irq_req, ack, stk_push, stk_pop, vec_rd, pc_load;
    logic flags_load, fast_status, busy;
    logic [15:0] pc_new;
    logic [15:0] pcq[$];
    logic [7:0] bq[$];
    logic [7:0] flq[$];
    logic [7:0] exp_b [5] = '{8'h34, 8'h12, 8'h3C, 8'h84, 8'h85};
    int errors = 0;
    int n_checks = 0;
    int n_ack = 0;
    // Free-running 50 MHz clock
    always #10 ref_clk = ~ref_clk;
    eip_unit eip_unit_i (.ref_clk(ref_clk), .rstn(rstn), .ce(1'b1),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .src_req(src_req), .src_en(src_en),
        .src_sw_clr(src_sw_clr), .instr_end(pv[0]),
        .return_from_interrupt(pv[1]), .global_enable_instr(pv[2]),
        .global_disable_instr(pv[3]), .pc_in(16'h1234), .flags_in(8'h3C),
        .vec_rdata(vec_rdata), .stk_rdata(stk_rdata), .irq_req(irq_req),
        .acknowledge_strobe(ack), .stk_push(stk_push), .stk_wdata(stk_wdata),
        .stk_pop(stk_pop), .vec_rd(vec_rd), .vec_addr(vec_addr),
        .pc_load(pc_load), .pc_new(pc_new), .flags_load(flags_load),
        .flags_new(flags_new), .fast_status(fast_status), .busy(busy));
    eip_cpu_model eip_cpu_model_i (.ref_clk(ref_clk), .stk_push(stk_push),
        .stk_wdata(stk_wdata), .stk_pop(stk_pop), .vec_rd(vec_rd),
        .vec_addr(vec_addr), .vec_rdata(vec_rdata), .stk_rdata(stk_rdata));
    // Log stack, vector and load traffic in order
    always @(posedge ref_clk) begin
        if (stk_push) bq.push_back(stk_wdata);
        if (vec_rd) bq.push_back(vec_addr);
        if (pc_load) pcq.push_back(pc_new);
        if (flags_load) flq.push_back(flags_new);
        if (ack) n_ack++;
    end
    function logic [15:0] vec(input int s);
        return {8'h80 + 8'(2 * s), 8'h81 + 8'(2 * s)} ^ 16'h5A5A;
    endfunction
    task results;
        if (errors == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(negedge ref_clk) reg_wr = 1'b0;
    endtask
    // Status reads lag one extra cycle, so wait three
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge ref_clk) reg_addr = a;
        repeat (3) @(negedge ref_clk);
        chk(16'(reg_rdata), 16'(e));
    endtask
    task pulse(input int k);
        @(negedge ref_clk) pv[k] = 1'b1;
        @(negedge ref_clk) pv[k] = 1'b0;
    endtask
    task req(input logic [15:0] m);
        @(negedge ref_clk) src_req = m;
        @(negedge ref_clk) src_req = 16'h0000;
    endtask
    // Start entry or return, then wait for the PC load
    task go(input int k, input logic [15:0] exp);
        int i;
        pulse(k);
        for (i = 0; i < 30 && pcq.size() == 0; i++) @(negedge ref_clk);
        if (pcq.size() == 0) begin
            errors++;
            results;
        end
        repeat (4) @(negedge ref_clk);
        chk(pcq.pop_front(), exp);
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        @(negedge ref_clk) rstn = 1'b1;
        rd(8'hDC, 8'h00);
        rd(8'hDE, 8'h00);
        wr(8'hDA, 8'hAB);
        wr(8'hDB, 8'hCD);
        rd(8'hDA, 8'hAB);
        rd(8'hDB, 8'hCD);
        wr(8'hDC, 8'hFF);
        rd(8'hDC, 8'h00);
        wr(8'hDD, 8'hFF);
        wr(8'hFF, 8'h01);
        req(16'h0005);
        rd(8'hDC, 8'h03);
        chk(16'(irq_req), 16'h0000);
        pulse(2);
        go(0, vec(2));
        chk(16'(bq.size()), 16'h0005);
        foreach (exp_b[i]) chk(16'(bq[i]), 16'(exp_b[i]));
        bq.delete();
        rd(8'hDC, 8'h01);
        rd(8'hDE, 8'h00);
        go(1, 16'h1234);
        chk(16'(flq.pop_front()), 16'h003C);
        rd(8'hDE, 8'h01);
        pulse(3);
        @(negedge ref_clk);
        chk(16'(irq_req), 16'h0000);
        wr(8'hDE, 8'h07);
        req(16'h0004);
        go(0, 16'hABCD);
        chk(16'(fast_status), 16'h0001);
        chk(16'(bq.size()), 16'h0000);
        go(1, 16'h1234);
        chk(16'(flq.pop_front()), 16'h003C);
        chk(16'(fast_status), 16'h0000);
        wr(8'hDE, 8'h01);
        wr(8'hDD, 8'hFE);
        @(negedge ref_clk);
        chk(16'(irq_req), 16'h0000);
        wr(8'hDD, 8'hFF);
        @(negedge ref_clk) src_en = 16'hFFFE;
        repeat (3) @(negedge ref_clk);
        chk(16'(irq_req), 16'h0000);
        src_en = 16'hFFFF;
        @(negedge ref_clk);
        chk(16'(irq_req), 16'h0001);
        go(0, vec(0));
        go(1, 16'h1234);
        wr(8'hFF, 8'h82);
        req(16'h0410);
        go(0, vec(10));
        go(1, 16'h1234);
        wr(8'hFF, 8'h02);
        go(0, vec(4));
        go(1, 16'h1234);
        rd(8'hDC, 8'h20);
        @(negedge ref_clk) src_sw_clr = 16'h0400;
        @(negedge ref_clk) src_sw_clr = 16'h0000;
        rd(8'hDC, 8'h00);
        chk(16'(n_ack), 16'h0005);
        results;
    end
endmodule
